// File: inc/orx_pkg.sv
// Package with the operation codes, carrier types and widths of the execute block.
package orx_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 11;
    localparam int ADDR_W = 8;
    localparam int STACK_DEPTH = 4;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [10:0] PC_RESET = 11'h000;
    localparam logic [10:0] IRQ_VECTOR = 11'h004;
    localparam int ZERO_FLAG_POS = 0;
    localparam logic ZERO_RESET = 1'h0;
    localparam logic GIE_RESET = 1'h0;
    localparam logic [1:0] SP_RESET = 2'h0;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_UNION_IMM,
        OP_UNION_ACC_INTO_MEMORY,
        OP_SUBROUTINE_EXIT,
        OP_SUBROUTINE_EXIT_LOAD_ACC,
        OP_INTERRUPT_EXIT,
        OP_ROTATE_LEFT_MEMORY,
        OP_ROTATE_LEFT_TO_ACC
    } orx_op_t;

    typedef struct packed {
        orx_op_t op;
        logic [7:0] imm;
        logic [7:0] addr;
    } orx_instr_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } orx_mem_wr_t;
endpackage

// File: logic/orx_exec.sv
// Execute stage for the OR, return and rotate-left instruction group.
// How it works
// - OR immediate into accumulator; only the zero flag changes.
// - OR accumulator with memory byte, store to memory; only zero flag changes.
// - Plain return pops the stack into the program counter, flags untouched.
// - Return with immediate pops program counter and loads accumulator, no flags.
// - Interrupt return with no request pending pops program counter and sets global interrupt enable.
// - A pending interrupt at interrupt return is serviced before the main program.
// - Rotate memory byte left, bit seven into bit zero, write back, no flags.
// - Rotate memory byte left into accumulator, memory unchanged, no flags.
`timescale 1ns/1ps
module orx_exec (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RST_N,
    // Instruction issued this cycle and the memory byte it addresses.
    input wire orx_pkg::orx_instr_t INSTR,
    input wire logic [7:0] MEM_RDATA,
    // Interrupt request and vector entry from the core.
    input wire logic IRQ_PENDING,
    input wire logic IRQ_DISABLE,
    input wire logic [10:0] PUSH_PC,
    input wire logic PUSH,
    // Architectural state.
    output logic [7:0] ACC,
    output logic ZERO_FLAG,
    output logic GLOBAL_IRQ_ALLOW,
    output logic [10:0] PC,
    output logic PC_LOAD,
    output logic IRQ_TAKEN,
    // Data memory write.
    output orx_pkg::orx_mem_wr_t MEM_WR
);
    logic [7:0] acc_reg;
    logic zero_reg;
    logic gie_reg;
    logic [10:0] pc_reg;
    logic pc_load_reg;
    logic irq_taken_reg;
    orx_pkg::orx_mem_wr_t mem_wr_reg;
    logic [10:0] stack_reg [orx_pkg::STACK_DEPTH];
    logic [1:0] sp_reg;

    wire orx_pkg::orx_op_t op = INSTR.op;
    wire [7:0] union_imm = acc_reg | INSTR.imm;
    wire [7:0] union_mem = acc_reg | MEM_RDATA;
    wire [7:0] rotated = {MEM_RDATA[6:0], MEM_RDATA[7]};
    wire is_sub_exit = (op == orx_pkg::OP_SUBROUTINE_EXIT);
    wire is_sub_exit_acc = (op == orx_pkg::OP_SUBROUTINE_EXIT_LOAD_ACC);
    wire is_irq_exit = (op == orx_pkg::OP_INTERRUPT_EXIT);
    wire is_pop = is_sub_exit || is_sub_exit_acc || is_irq_exit;
    wire [1:0] sp_top = sp_reg - 2'h1;
    wire [10:0] popped_pc = stack_reg[sp_top];
    // Interrupt return with a request waiting: the pop is skipped so the return address stays
    // on the stack and control goes to the vector, so the handler runs before the main program.
    wire interrupt_exit_chain = is_irq_exit && IRQ_PENDING;
    // A push that meets a return is dropped, as the core never calls and returns at once.
    wire push_ok = PUSH && !is_pop;
    wire pop_ok = is_pop && !interrupt_exit_chain;

    logic [7:0] acc_next;
    logic zero_next;
    logic gie_next;
    logic [10:0] pc_next;
    logic pc_load_next;
    orx_pkg::orx_mem_wr_t mem_wr_next;

    always_comb
    begin
        acc_next = acc_reg;
        zero_next = zero_reg;
        gie_next = IRQ_DISABLE ? 1'b0 : gie_reg;
        pc_next = pc_reg;
        pc_load_next = 1'b0;
        mem_wr_next = '0;
        unique case (op)
            orx_pkg::OP_NONE:
            begin
            end
            orx_pkg::OP_UNION_IMM:
            begin
                acc_next = union_imm;
                zero_next = (union_imm == 8'h00);
            end
            orx_pkg::OP_UNION_ACC_INTO_MEMORY:
            begin
                mem_wr_next = '{wr: 1'b1, addr: INSTR.addr, data: union_mem};
                zero_next = (union_mem == 8'h00);
            end
            orx_pkg::OP_SUBROUTINE_EXIT:
            begin
                pc_next = popped_pc;
                pc_load_next = 1'b1;
            end
            orx_pkg::OP_SUBROUTINE_EXIT_LOAD_ACC:
            begin
                pc_next = popped_pc;
                pc_load_next = 1'b1;
                acc_next = INSTR.imm;
            end
            orx_pkg::OP_INTERRUPT_EXIT:
            begin
                pc_load_next = 1'b1;
                if (interrupt_exit_chain)
                begin
                    pc_next = orx_pkg::IRQ_VECTOR;
                    gie_next = 1'b0;
                end
                else
                begin
                    pc_next = popped_pc;
                    gie_next = 1'b1;
                end
            end
            orx_pkg::OP_ROTATE_LEFT_MEMORY:
            begin
                mem_wr_next = '{wr: 1'b1, addr: INSTR.addr, data: rotated};
            end
            orx_pkg::OP_ROTATE_LEFT_TO_ACC:
            begin
                acc_next = rotated;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            acc_reg <= orx_pkg::ACC_RESET;
        end
        else
        begin
            acc_reg <= acc_next;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            zero_reg <= orx_pkg::ZERO_RESET;
        end
        else
        begin
            zero_reg <= zero_next;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            gie_reg <= orx_pkg::GIE_RESET;
        end
        else
        begin
            gie_reg <= gie_next;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pc_reg <= orx_pkg::PC_RESET;
        end
        else
        begin
            pc_reg <= pc_next;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            pc_load_reg <= 1'b0;
        end
        else
        begin
            pc_load_reg <= pc_load_next;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            irq_taken_reg <= 1'b0;
        end
        else
        begin
            irq_taken_reg <= interrupt_exit_chain;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mem_wr_reg <= '0;
        end
        else
        begin
            mem_wr_reg <= mem_wr_next;
        end
    end

    // Stack pointer wraps silently; overflow behaviour is left to software as in
    // small cores without stack-full detection.
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sp_reg <= orx_pkg::SP_RESET;
        end
        else if (push_ok)
        begin
            sp_reg <= sp_reg + 2'h1;
        end
        else if (pop_ok)
        begin
            sp_reg <= sp_top;
        end
    end

    // Each slot loads only when the pointer names it, so a pop never disturbs stored addresses.
    for (genvar slot = 0; slot < orx_pkg::STACK_DEPTH; slot++)
    begin : stack_slot
        wire slot_load = push_ok && (sp_reg == 2'(slot));
        always_ff @(posedge CLOCK)
        begin
            if (slot_load)
            begin
                stack_reg[slot] <= PUSH_PC;
            end
        end
    end

    assign ACC = acc_reg;
    assign ZERO_FLAG = zero_reg;
    assign GLOBAL_IRQ_ALLOW = gie_reg;
    assign PC = pc_reg;
    assign PC_LOAD = pc_load_reg;
    assign IRQ_TAKEN = irq_taken_reg;
    assign MEM_WR = mem_wr_reg;
endmodule

// File: testbench/orx_exec_properties.sv
// Checker of the execute block's port relations.
`timescale 1ns/1ps
module orx_exec_properties (
    // Clock, reset and single-bit signals.
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic IRQ_PENDING,
    input wire logic IRQ_DISABLE,
    input wire logic ZERO_FLAG,
    input wire logic GLOBAL_IRQ_ALLOW,
    input wire logic PC_LOAD,
    input wire logic IRQ_TAKEN,
    // Buses.
    input wire orx_pkg::orx_instr_t INSTR,
    input wire logic [7:0] MEM_RDATA,
    input wire logic [7:0] ACC,
    input wire logic [10:0] PC,
    input wire orx_pkg::orx_mem_wr_t MEM_WR
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    wire [2:0] op = INSTR.op;
    wire [7:0] rot = {MEM_RDATA[6:0], MEM_RDATA[7]};
    sequence pop_s;
        PC_LOAD && !IRQ_TAKEN && !MEM_WR.wr && $stable(ZERO_FLAG);
    endsequence
    or_imm_a: assert property (op == 3'h1 |=> ACC == ($past(ACC) | $past(INSTR.imm))
        && ZERO_FLAG == (ACC == 8'h00) && !MEM_WR.wr) else $error("or imm");
    or_mem_a: assert property (op == 3'h2 |=> MEM_WR.wr && ZERO_FLAG == (MEM_WR.data == 8'h00)
        && MEM_WR.data == ($past(ACC) | $past(MEM_RDATA)) && $stable(ACC)) else $error("or mem");
    plain_return_a: assert property (op == 3'h3 |=> pop_s and $stable(ACC))
        else $error("plain return");
    return_load_a: assert property (op == 3'h4 |=> pop_s and ACC == $past(INSTR.imm))
        else $error("return with load");
    irq_return_a: assert property (op == 3'h5 && !IRQ_PENDING |=> pop_s and GLOBAL_IRQ_ALLOW)
        else $error("interrupt return");
    irq_chain_a: assert property (op == 3'h5 && IRQ_PENDING
        |=> IRQ_TAKEN && PC_LOAD && PC == orx_pkg::IRQ_VECTOR && !GLOBAL_IRQ_ALLOW)
        else $error("interrupt chain");
    idle_quiet_a: assert property (op == 3'h0 && !IRQ_DISABLE |=> !PC_LOAD && !IRQ_TAKEN
        && !MEM_WR.wr && $stable(ACC) && $stable(ZERO_FLAG) && $stable(GLOBAL_IRQ_ALLOW))
        else $error("idle not quiet");
    irq_disable_a: assert property (IRQ_DISABLE && op != 3'h5 |=> !GLOBAL_IRQ_ALLOW)
        else $error("enable not cleared");
    rl_mem_a: assert property (op == 3'h6 |=> MEM_WR.wr && MEM_WR.data == $past(rot)
        && MEM_WR.addr == $past(INSTR.addr) && $stable(ZERO_FLAG)) else $error("rl mem");
    rl_acc_a: assert property (op == 3'h7 |=> !MEM_WR.wr && ACC == $past(rot)
        && $stable(ZERO_FLAG)) else $error("rl acc");
endmodule
bind orx_exec orx_exec_properties u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .IRQ_PENDING(IRQ_PENDING),
    .IRQ_DISABLE(IRQ_DISABLE), .ZERO_FLAG(ZERO_FLAG), .GLOBAL_IRQ_ALLOW(GLOBAL_IRQ_ALLOW),
    .PC_LOAD(PC_LOAD), .IRQ_TAKEN(IRQ_TAKEN), .INSTR(INSTR), .MEM_RDATA(MEM_RDATA), .ACC(ACC),
    .PC(PC), .MEM_WR(MEM_WR));

// File: testbench/orx_exec_tb_top.sv
// Random bench for the execute block against a queue model.
`timescale 1ns/1ps
module orx_exec_tb_top;
    logic CLOCK = 0, RST_N = 0, IRQ_PENDING = 0, IRQ_DISABLE = 0, PUSH = 0;
    logic ZERO_FLAG, GLOBAL_IRQ_ALLOW, PC_LOAD, IRQ_TAKEN;
    logic [7:0] MEM_RDATA = 8'h00, ACC;
    logic [10:0] PUSH_PC = 11'h000, PC;
    orx_pkg::orx_instr_t INSTR = '0;
    orx_pkg::orx_mem_wr_t MEM_WR;
    int bad_count = 0, tests_run = 0, seed = 32'hfa7c_0262;
    int acc = 0, z = 0, gie = 0, pc = 0, pl = 0, it = 0, wr = 0, wd = 0, wa = 0, r, o;
    int st[$];
    orx_exec orx_exec_inst (.CLOCK(CLOCK), .RST_N(RST_N), .INSTR(INSTR), .MEM_RDATA(MEM_RDATA),
        .IRQ_PENDING(IRQ_PENDING), .IRQ_DISABLE(IRQ_DISABLE), .PUSH_PC(PUSH_PC), .PUSH(PUSH),
        .ACC(ACC), .ZERO_FLAG(ZERO_FLAG), .GLOBAL_IRQ_ALLOW(GLOBAL_IRQ_ALLOW), .PC(PC),
        .PC_LOAD(PC_LOAD), .IRQ_TAKEN(IRQ_TAKEN), .MEM_WR(MEM_WR));
    initial forever #12.5 CLOCK = ~CLOCK;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_state(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp);
    endtask
    task automatic chk_pc(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp);
    endtask
    task automatic chk_mem(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp);
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(negedge CLOCK);
        RST_N = 1;
        for (int i = 0; i < 3000; i++)
        begin
            @(negedge CLOCK);
            chk_state(ACC, acc);
            chk_state(ZERO_FLAG, z);
            chk_state(GLOBAL_IRQ_ALLOW, gie);
            chk_pc(PC_LOAD, pl);
            chk_pc(IRQ_TAKEN, it);
            if (pl) chk_pc(PC, pc);
            chk_mem(MEM_WR.wr, wr);
            if (wr) chk_mem({MEM_WR.addr, MEM_WR.data}, {wa[7:0], wd[7:0]});
            r = $random(seed);
            o = r[2:0];
            // The model stack has no wrap, so pops and pushes stay inside its depth.
            if (o inside {3, 4, 5} && st.size() == 0) o = 0;
            INSTR = {orx_pkg::orx_op_t'(o[2:0]), r[15:8] & {8{r[29]}}, r[31:24]};
            MEM_RDATA = r[23:16] & {8{r[30]}};
            IRQ_PENDING = r[3];
            IRQ_DISABLE = r[5] && o != 5;
            PUSH = r[4] && st.size() < 4 && !(o inside {3, 4, 5});
            PUSH_PC = r[14:4];
            if (o == 1) acc = acc | INSTR.imm;
            if (o == 4) acc = INSTR.imm;
            if (o == 7) acc = {MEM_RDATA[6:0], MEM_RDATA[7]};
            wr = o == 2 || o == 6;
            wa = INSTR.addr;
            wd = o == 2 ? (acc | MEM_RDATA) : {MEM_RDATA[6:0], MEM_RDATA[7]};
            if (o == 1) z = acc == 0;
            if (o == 2) z = wd == 0;
            pl = o inside {3, 4, 5};
            it = o == 5 && IRQ_PENDING;
            if (it) pc = orx_pkg::IRQ_VECTOR;
            else if (pl) pc = st.pop_back();
            if (o == 5) gie = !it;
            if (IRQ_DISABLE) gie = 0;
            if (PUSH) st.push_back(PUSH_PC);
        end
        report_and_stop();
    end
endmodule
